// >>> include/sanm_pkg.sv
package sanm_pkg;

    // Register indices; byte address is four times the index
    localparam logic [3:0] IDX_STATUS   = 4'h1;
    localparam logic [3:0] IDX_ID_UPPER = 4'h2;
    localparam logic [3:0] IDX_ID_LOWER = 4'h3;
    localparam logic [3:0] IDX_ADVERT   = 4'h4;
    localparam logic [3:0] IDX_PARTNER  = 4'h5;
    localparam logic [3:0] IDX_EXPAND   = 4'h6;
    localparam logic [3:0] IDX_NP_TX    = 4'h7;
    localparam logic [3:0] IDX_NP_RX    = 4'h8;

    // Field positions
    localparam int STAT_AN_DONE    = 5;
    localparam int PTN_LINK        = 15;
    localparam int PTN_ACK         = 14;
    localparam int PTN_DUPLEX      = 12;
    localparam int PTN_SPEED_LO    = 10;
    localparam int PTN_ONE         = 0;
    localparam int EXP_NP_ABLE     = 2;
    localparam int EXP_PAGE_RX     = 1;
    localparam int NP_MORE         = 15;
    localparam int NP_ACK          = 14;
    localparam int NP_MSG          = 13;
    localparam int NP_ACK2         = 12;
    localparam int NP_TOGGLE       = 11;
    localparam int OUI_UPPER_FIRST = 3;
    localparam int OUI_LOWER_FIRST = 19;

    // Values after reset and fixed words
    localparam logic [15:0] ADVERT_WORD   = 16'h0000;
    localparam logic        PTN_LINK_RST  = 1'h1;
    localparam logic        NP_MORE_RST   = 1'h0;
    localparam logic        NP_MSG_RST    = 1'h1;
    localparam logic        NP_ACK2_RST   = 1'h0;
    localparam logic [10:0] NP_CODE_RST   = 11'h000;
    localparam logic        TOGGLE_RST    = 1'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : sanm_pkg

// >>> hdl/sanm_regs.sv
// Notes on behaviour
// - ID registers return vendor identifier bits 3-18 and 19-24 in fixed places.
// - Advertisement register is read-only, holding fixed word sent to PHY.
// - Partner bit 15 reports PHY line link; resets to one.
// - Partner bit 14 set when a base or next page arrives.
// - Partner bit 12 reports resolved duplex, one meaning full.
// - Partner bits 11:10 report resolved speed; code three reserved.
// - Partner bits 13 and 9:1 read zero, bit 0 reads one.
// - Expansion bit 2 reads one; other unused bits read zero.
// - Expansion bit 1 set on new page, cleared by reading.
// - Transmit bit 15 writable more-pages flag, resets zero; bit 14 zero.
// - Transmit bit 13 message select resets one; bits 10:0 writable code.
// - Transmit bit 12 writable comply flag, resets zero.
// - Transmit toggle flips on each sent next page, zero after reset.
// - Receive register captures partner next page fields, all reset zero.
// - Receive bit 11 holds toggle of received next page.
// - Receive bit 14 set when a partner page arrives.
// - Status bit 5 shows negotiation complete; resets zero.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sanm_regs #(
    parameter logic [1:24] VENDOR_OUI = 24'h5a3c96  // Arbitrary identifier value; bit 1 is the leftmost
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_in,
    // AXI4-Lite slave
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output var  logic        s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output var  logic        s_axi_wready_out,
    output var  logic [1:0]  s_axi_bresp_out,
    output var  logic        s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output var  logic        s_axi_arready_out,
    output var  logic [31:0] s_axi_rdata_out,
    output var  logic [1:0]  s_axi_rresp_out,
    output var  logic        s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    // Auto-negotiation function side
    input  wire logic        an_complete_in,
    input  wire logic        base_page_rx_in,
    input  wire logic        ptn_link_up_in,
    input  wire logic        ptn_full_duplex_in,
    input  wire logic [1:0]  ptn_speed_in,
    input  wire logic        next_page_rx_in,
    input  wire logic [15:0] next_page_word_in,
    input  wire logic        next_page_sent_in,
    output var  logic [15:0] advert_word_out,
    output var  logic [15:0] np_tx_word_out
);

    // Write channel state
    logic        aw_hold_reg;
    logic [3:0]  aw_idx_reg;
    logic        aw_bad_reg;
    logic        w_hold_reg;
    logic [15:0] w_data_reg;
    logic [1:0]  w_strb_reg;
    logic        awready_reg;
    logic        wready_reg;
    logic        bvalid_reg;
    logic [1:0]  bresp_reg;
    // Read channel state
    logic        arready_reg;
    logic        rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0]  rresp_reg;
    // Register contents
    logic        an_done_reg;
    logic        ptn_link_reg;
    logic        ptn_ack_reg;
    logic        ptn_duplex_reg;
    logic [1:0]  ptn_speed_reg;
    logic        page_rx_reg;
    logic        np_more_reg;
    logic        np_msg_reg;
    logic        np_ack2_reg;
    logic [10:0] np_code_reg;
    logic        np_toggle_reg;
    logic [15:0] np_rx_reg;
    logic        np_rx_ack_reg;
    logic [15:0] advert_reg;
    logic [15:0] np_tx_word_reg;

    // Vendor identifier words
    logic [15:0] id_upper_word;
    logic [15:0] id_lower_word;

    genvar gi;
    generate
        for (gi = 0; gi < 16; gi++) begin : g_id_upper
            assign id_upper_word[15 - gi] = VENDOR_OUI[sanm_pkg::OUI_UPPER_FIRST + gi];
        end
        for (gi = 0; gi < 6; gi++) begin : g_id_lower
            assign id_lower_word[15 - gi] = VENDOR_OUI[sanm_pkg::OUI_LOWER_FIRST + gi];
        end
    endgenerate
    assign id_lower_word[9:0] = 10'h000;

    // Handshake terms
    wire aw_take  = s_axi_awvalid_in & awready_reg;
    wire w_take   = s_axi_wvalid_in & wready_reg;
    wire do_write = aw_hold_reg & w_hold_reg & ~bvalid_reg;
    wire ar_take  = s_axi_arvalid_in & arready_reg;

    wire aw_hold_next = (aw_hold_reg | aw_take) & ~do_write;
    wire w_hold_next  = (w_hold_reg | w_take) & ~do_write;
    wire bvalid_next  = do_write | (bvalid_reg & ~s_axi_bready_in);
    wire rvalid_next  = ar_take | (rvalid_reg & ~s_axi_rready_in);

    // Address decode
    wire [3:0] aw_idx    = s_axi_awaddr_in[5:2];
    wire [3:0] ar_idx    = s_axi_araddr_in[5:2];
    wire       aw_mapped = (s_axi_awaddr_in[7:6] == 2'h0) && (aw_idx >= sanm_pkg::IDX_STATUS)
                           && (aw_idx <= sanm_pkg::IDX_NP_RX);
    wire       ar_mapped = (s_axi_araddr_in[7:6] == 2'h0) && (ar_idx >= sanm_pkg::IDX_STATUS)
                           && (ar_idx <= sanm_pkg::IDX_NP_RX);

    // Words as read back
    wire [15:0] status_word  = 16'(an_done_reg) << sanm_pkg::STAT_AN_DONE;
    wire [15:0] partner_word = {ptn_link_reg, ptn_ack_reg, 1'h0, ptn_duplex_reg,
                                ptn_speed_reg, 9'h000, 1'h1};
    wire [15:0] expand_word  = {13'h0000, 1'h1, page_rx_reg, 1'h0};
    wire [15:0] np_tx_word   = {np_more_reg, 1'h0, np_msg_reg, np_ack2_reg,
                                np_toggle_reg, np_code_reg};
    wire [15:0] np_rx_word   = {np_rx_reg[15], np_rx_ack_reg, np_rx_reg[13:0]};

    wire [15:0] rd_word = (ar_idx == sanm_pkg::IDX_STATUS)   ? status_word   :
                          (ar_idx == sanm_pkg::IDX_ID_UPPER) ? id_upper_word :
                          (ar_idx == sanm_pkg::IDX_ID_LOWER) ? id_lower_word :
                          (ar_idx == sanm_pkg::IDX_ADVERT)   ? advert_reg    :
                          (ar_idx == sanm_pkg::IDX_PARTNER)  ? partner_word  :
                          (ar_idx == sanm_pkg::IDX_EXPAND)   ? expand_word   :
                          (ar_idx == sanm_pkg::IDX_NP_TX)    ? np_tx_word    :
                          (ar_idx == sanm_pkg::IDX_NP_RX)    ? np_rx_word    : 16'h0000;

    // Write effects; only the transmit page register has writable fields
    wire wr_np_tx = do_write & ~aw_bad_reg & (aw_idx_reg == sanm_pkg::IDX_NP_TX);
    wire wr_lo    = wr_np_tx & w_strb_reg[0];
    wire wr_hi    = wr_np_tx & w_strb_reg[1];
    wire any_page = base_page_rx_in | next_page_rx_in;
    wire rd_clear = ar_take & ar_mapped & (ar_idx == sanm_pkg::IDX_EXPAND);

    // Write address and data capture
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            aw_hold_reg <= 1'h0;
            aw_idx_reg  <= 4'h0;
            aw_bad_reg  <= 1'h0;
            w_hold_reg  <= 1'h0;
            w_data_reg  <= 16'h0000;
            w_strb_reg  <= 2'h0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg  <= w_hold_next;
            if (aw_take) begin
                aw_idx_reg <= aw_idx;
                aw_bad_reg <= ~aw_mapped;
            end
            if (w_take) begin
                w_data_reg <= s_axi_wdata_in[15:0];
                w_strb_reg <= s_axi_wstrb_in[1:0];
            end
        end
    end

    // Write ready and response
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            awready_reg <= 1'h0;
            wready_reg  <= 1'h0;
            bvalid_reg  <= 1'h0;
            bresp_reg   <= sanm_pkg::RESP_OKAY;
        end else begin
            awready_reg <= ~aw_hold_next & ~bvalid_next;
            wready_reg  <= ~w_hold_next & ~bvalid_next;
            bvalid_reg  <= bvalid_next;
            if (do_write) begin
                bresp_reg <= aw_bad_reg ? sanm_pkg::RESP_SLVERR : sanm_pkg::RESP_OKAY;
            end
        end
    end

    // Read channel
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            arready_reg <= 1'h0;
            rvalid_reg  <= 1'h0;
            rdata_reg   <= 32'h0000_0000;
            rresp_reg   <= sanm_pkg::RESP_OKAY;
        end else begin
            arready_reg <= ~rvalid_next;
            rvalid_reg  <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= ar_mapped ? {16'h0000, rd_word} : 32'h0000_0000;
                rresp_reg <= ar_mapped ? sanm_pkg::RESP_OKAY : sanm_pkg::RESP_SLVERR;
            end
        end
    end

    // Negotiation status and partner base page
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            an_done_reg    <= 1'h0;
            ptn_link_reg   <= sanm_pkg::PTN_LINK_RST;
            ptn_ack_reg    <= 1'h0;
            ptn_duplex_reg <= 1'h0;
            ptn_speed_reg  <= 2'h0;
        end else begin
            an_done_reg <= an_complete_in;
            if (base_page_rx_in) begin
                ptn_link_reg   <= ptn_link_up_in;
                ptn_duplex_reg <= ptn_full_duplex_in;
                ptn_speed_reg  <= ptn_speed_in;
            end
            if (any_page) begin
                ptn_ack_reg <= 1'h1;
            end
        end
    end

    // Page received flag; a new page beats the read clear
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            page_rx_reg <= 1'h0;
        end else if (any_page) begin
            page_rx_reg <= 1'h1;
        end else if (rd_clear) begin
            page_rx_reg <= 1'h0;
        end
    end

    // Next page transmit fields
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            np_more_reg   <= sanm_pkg::NP_MORE_RST;
            np_msg_reg    <= sanm_pkg::NP_MSG_RST;
            np_ack2_reg   <= sanm_pkg::NP_ACK2_RST;
            np_code_reg   <= sanm_pkg::NP_CODE_RST;
            np_toggle_reg <= sanm_pkg::TOGGLE_RST;
        end else begin
            if (wr_hi) begin
                np_more_reg     <= w_data_reg[sanm_pkg::NP_MORE];
                np_msg_reg      <= w_data_reg[sanm_pkg::NP_MSG];
                np_ack2_reg     <= w_data_reg[sanm_pkg::NP_ACK2];
                np_code_reg[10:8] <= w_data_reg[10:8];
            end
            if (wr_lo) begin
                np_code_reg[7:0] <= w_data_reg[7:0];
            end
            if (next_page_sent_in) begin
                np_toggle_reg <= ~np_toggle_reg;
            end
        end
    end

    // Partner next page capture
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            np_rx_reg     <= 16'h0000;
            np_rx_ack_reg <= 1'h0;
        end else begin
            if (next_page_rx_in) begin
                np_rx_reg <= next_page_word_in & 16'hbfff;
            end
            if (any_page) begin
                np_rx_ack_reg <= 1'h1;
            end
        end
    end

    // Words handed to the negotiation function
    always_ff @(posedge ref_clk_in) begin
        if (rst_in) begin
            advert_reg     <= sanm_pkg::ADVERT_WORD;
            np_tx_word_reg <= 16'h0000;
        end else begin
            advert_reg     <= sanm_pkg::ADVERT_WORD;
            np_tx_word_reg <= np_tx_word;
        end
    end

    assign s_axi_awready_out = awready_reg;
    assign s_axi_wready_out  = wready_reg;
    assign s_axi_bvalid_out  = bvalid_reg;
    assign s_axi_bresp_out   = bresp_reg;
    assign s_axi_arready_out = arready_reg;
    assign s_axi_rvalid_out  = rvalid_reg;
    assign s_axi_rdata_out   = rdata_reg;
    assign s_axi_rresp_out   = rresp_reg;
    assign advert_word_out   = advert_reg;
    assign np_tx_word_out    = np_tx_word_reg;

    // Checks
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (rst_in);

    chk_id_upper_word: assert property (
        ar_take && ar_mapped && ar_idx == sanm_pkg::IDX_ID_UPPER |=> rdata_reg[15:0] == id_upper_word)
        else $error("Identifier upper word wrong");

    chk_advert_fixed: assert property (
        ar_take && ar_mapped && ar_idx == sanm_pkg::IDX_ADVERT
        |=> rdata_reg[15:0] == sanm_pkg::ADVERT_WORD && advert_word_out == sanm_pkg::ADVERT_WORD)
        else $error("Advertisement word changed");

    chk_link_capture: assert property (
        base_page_rx_in |=> partner_word[sanm_pkg::PTN_LINK] == $past(ptn_link_up_in))
        else $error("Partner link not captured");

    chk_ack_set: assert property (
        any_page |=> ptn_ack_reg && np_rx_ack_reg)
        else $error("Acknowledge flag not set");

    chk_speed_duplex: assert property (
        base_page_rx_in |=> ptn_speed_reg == $past(ptn_speed_in)
                            && ptn_duplex_reg == $past(ptn_full_duplex_in))
        else $error("Speed or duplex not captured");

    chk_partner_fixed: assert property (
        ar_take && ar_mapped && ar_idx == sanm_pkg::IDX_PARTNER
        |=> rdata_reg[9:0] == 10'h001 && !rdata_reg[13])
        else $error("Partner fixed bits wrong");

    chk_expand_fixed: assert property (
        ar_take && ar_mapped && ar_idx == sanm_pkg::IDX_EXPAND
        |=> rdata_reg[15:3] == 13'h0000 && rdata_reg[sanm_pkg::EXP_NP_ABLE] && !rdata_reg[0])
        else $error("Expansion fixed bits wrong");

    chk_page_rx_clear: assert property (
        rd_clear && !any_page |=> !page_rx_reg)
        else $error("Page received not cleared on read");

    chk_page_rx_wins: assert property (
        any_page |=> page_rx_reg ##1 (page_rx_reg || $past(rd_clear)))
        else $error("Page received lost");

    chk_toggle_flip: assert property (
        next_page_sent_in |=> np_toggle_reg != $past(np_toggle_reg))
        else $error("Transmit toggle did not flip");

    chk_rx_toggle: assert property (
        next_page_rx_in |=> np_rx_word[sanm_pkg::NP_TOGGLE] == $past(next_page_word_in[11]))
        else $error("Received toggle not captured");

    chk_np_tx_write: assert property (
        wr_hi |=> np_more_reg == $past(w_data_reg[sanm_pkg::NP_MORE])
                  && np_msg_reg == $past(w_data_reg[sanm_pkg::NP_MSG])
                  && np_ack2_reg == $past(w_data_reg[sanm_pkg::NP_ACK2]))
        else $error("Transmit page fields not written");

    chk_np_rx_capture: assert property (
        next_page_rx_in |=> np_rx_reg == ($past(next_page_word_in) & 16'hbfff))
        else $error("Received page not captured");

    chk_an_done: assert property (
        1'b1 |=> an_done_reg == $past(an_complete_in))
        else $error("Negotiation complete not tracked");

    chk_ro_write: assert property (
        do_write && aw_idx_reg == sanm_pkg::IDX_PARTNER && !any_page && !base_page_rx_in
        |=> $stable(partner_word))
        else $error("Read-only register changed by write");

    chk_write_resp: assert property (
        do_write |=> bvalid_reg && !awready_reg && !wready_reg
                     && bresp_reg == ($past(aw_bad_reg) ? sanm_pkg::RESP_SLVERR : sanm_pkg::RESP_OKAY))
        else $error("Write response missing");

endmodule : sanm_regs

`default_nettype wire

// >>> verification/sanm_phy_model.sv
`timescale 1ns/1ps
`default_nettype none

// Negotiation side stand-in: delivers partner pages and status
module sanm_phy_model (
    input  wire logic        clk_in,
    output logic             an_done_out,
    output logic             base_pg_out,
    output logic             link_out,
    output logic             fdx_out,
    output logic [1:0]       spd_out,
    output logic             np_rx_out,
    output logic [15:0]      np_word_out,
    output logic             np_sent_out
);
    logic rx_tog_reg;

    // Idle levels at time zero
    initial begin
        an_done_out = 1'h0;
        base_pg_out = 1'h0;
        link_out = 1'h0;
        fdx_out = 1'h0;
        spd_out = 2'h0;
        np_rx_out = 1'h0;
        np_word_out = 16'h0000;
        np_sent_out = 1'h0;
        rx_tog_reg = 1'h0;
    end

    // Base page; fields go stale after the pulse
    task automatic base_page(input logic link, input logic fdx, input logic [1:0] spd);
        @(posedge clk_in);
        link_out <= link;
        fdx_out <= fdx;
        spd_out <= spd;
        base_pg_out <= 1'h1;
        @(posedge clk_in);
        base_pg_out <= 1'h0;
        link_out <= ~link;
        fdx_out <= ~fdx;
        spd_out <= ~spd;
    endtask : base_page

    // Next page; toggle alternates between pages
    task automatic next_page(input logic [15:0] word);
        @(posedge clk_in);
        np_word_out <= {word[15:12], rx_tog_reg, word[10:0]};
        np_rx_out <= 1'h1;
        rx_tog_reg = ~rx_tog_reg;
        @(posedge clk_in);
        np_rx_out <= 1'h0;
        np_word_out <= ~word;
    endtask : next_page

    // One transmitted next page
    task automatic sent_page();
        @(posedge clk_in);
        np_sent_out <= 1'h1;
        @(posedge clk_in);
        np_sent_out <= 1'h0;
    endtask : sent_page

    // Negotiation complete level
    task automatic set_done(input logic v);
        @(posedge clk_in);
        an_done_out <= v;
    endtask : set_done
endmodule : sanm_phy_model
`default_nettype wire

// >>> verification/sanm_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none

module sanm_regs_bench;
    localparam logic [1:24] TB_OUI = 24'h69b2d4;  // Arbitrary identifier value
    localparam logic [1:0]  OK = sanm_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR = sanm_pkg::RESP_SLVERR;
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [15:0] data;
        logic [3:0]  strb;
        logic [31:0] exp;
        logic [1:0]  resp;
    } sanm_row_s;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'h0;
    logic wvalid = 1'h0;
    logic bready = 1'h0;
    logic arvalid = 1'h0;
    logic rready = 1'h0;
    logic awready, wready, bvalid, arready, rvalid, an_done, base_pg, link, fdx, np_rx, np_sent;
    logic [1:0] bresp, rresp, spd;
    logic [31:0] rdata, rd;
    logic [15:0] advert, np_tx, np_word;
    logic [1:0] rs;
    int n_mismatch = 0;
    int num_checks = 0;
    sanm_row_s rows[$];

    sanm_regs #(.VENDOR_OUI(TB_OUI)) dut_u (.ref_clk_in(ref_clk), .rst_in(rst),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .an_complete_in(an_done), .base_page_rx_in(base_pg), .ptn_link_up_in(link), .ptn_full_duplex_in(fdx),
        .ptn_speed_in(spd), .next_page_rx_in(np_rx), .next_page_word_in(np_word),
        .next_page_sent_in(np_sent), .advert_word_out(advert), .np_tx_word_out(np_tx));

    sanm_phy_model phy_u (.clk_in(ref_clk), .an_done_out(an_done), .base_pg_out(base_pg), .link_out(link),
        .fdx_out(fdx), .spd_out(spd), .np_rx_out(np_rx), .np_word_out(np_word), .np_sent_out(np_sent));

    // Clock, 100 ns period
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s saw %h want %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic do_reset();
        rst <= 1'h1;
        repeat (6) @(posedge ref_clk);
        rst <= 1'h0;
        @(posedge ref_clk);
    endtask : do_reset

    // Write: address and data offered together, response awaited
    task automatic axi_write(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s, output logic [1:0] r);
        logic aw_ok, w_ok, b_ok;
        int n;
        {aw_ok, w_ok, b_ok} = 3'h0;
        n = 0;
        awaddr <= a;
        wdata <= {16'h0000, d};
        wstrb <= s;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        while (!b_ok && n < 100) begin
            @(posedge ref_clk);
            n++;
            if (aw_ok && w_ok && bvalid === 1'h1) begin
                r = bresp;
                b_ok = 1'h1;
                bready <= 1'h0;
            end
            if (!aw_ok && awready === 1'h1) begin
                aw_ok = 1'h1;
                awvalid <= 1'h0;
            end
            if (!w_ok && wready === 1'h1) begin
                w_ok = 1'h1;
                wvalid <= 1'h0;
            end
            if (!b_ok && aw_ok && w_ok) begin
                bready <= 1'h1;
            end
        end
        if (!b_ok) begin
            n_mismatch++;
            stop_test();
        end
    endtask : axi_write

    // Read: address held until taken, data taken with rvalid
    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ar_ok, r_ok;
        int n;
        {ar_ok, r_ok} = 2'h0;
        n = 0;
        araddr <= a;
        arvalid <= 1'h1;
        while (!r_ok && n < 100) begin
            @(posedge ref_clk);
            n++;
            if (ar_ok && rvalid === 1'h1) begin
                d = rdata;
                r = rresp;
                r_ok = 1'h1;
                rready <= 1'h0;
            end
            if (!ar_ok && arready === 1'h1) begin
                ar_ok = 1'h1;
                arvalid <= 1'h0;
                rready <= 1'h1;
            end
        end
        if (!r_ok) begin
            n_mismatch++;
            stop_test();
        end
    endtask : axi_read

    function automatic sanm_row_s row(logic w, logic [7:0] a, logic [15:0] d, logic [31:0] e, logic [1:0] r);
        return '{w, a, d, 4'hf, e, r};
    endfunction : row

    function automatic logic [31:0] id_word(input int first, input int cnt);
        logic [31:0] v;
        v = 32'h0;
        for (int i = 0; i < cnt; i++) begin
            v[15 - i] = TB_OUI[first + i];
        end
        return v;
    endfunction : id_word

    // Watchdog, well beyond the expected run
    initial begin
        repeat (5000) @(posedge ref_clk);
        $display("watchdog expired");
        n_mismatch++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [15:0] w;
        do_reset();
        rows = '{row(0, 8'h04, 0, 0, OK), row(0, 8'h08, 0, id_word(3, 16), OK), row(0, 8'h0c, 0, id_word(19, 6), OK),
            row(0, 8'h10, 0, 0, OK), row(0, 8'h14, 0, 32'h8001, OK), row(0, 8'h18, 0, 32'h0004, OK),
            row(0, 8'h1c, 0, 32'h2000, OK), row(0, 8'h20, 0, 0, OK), row(1, 8'h04, 16'hffff, 0, OK),
            row(1, 8'h10, 16'hffff, 0, OK), row(1, 8'h14, 16'hffff, 0, OK), row(1, 8'h18, 16'hffff, 0, OK),
            row(1, 8'h20, 16'hffff, 0, OK), row(1, 8'h1c, 16'hffff, 0, OK), row(0, 8'h1c, 0, 32'hb7ff, OK),
            row(0, 8'h04, 0, 0, OK), row(0, 8'h10, 0, 0, OK), row(0, 8'h14, 0, 32'h8001, OK),
            row(0, 8'h18, 0, 32'h0004, OK), row(0, 8'h20, 0, 0, OK), row(1, 8'h24, 16'h1234, 0, ERR),
            row(0, 8'h24, 0, 0, ERR), row(0, 8'h00, 0, 0, ERR), row(0, 8'h44, 0, 0, ERR)};
        rows[13].strb = 4'hf;
        rows.push_back('{1'h1, 8'h1c, 16'h5a5a, 4'h1, 32'h0, OK});
        rows.push_back('{1'h1, 8'h1c, 16'h4a00, 4'h2, 32'h0, OK});
        rows.push_back(row(0, 8'h1c, 0, 32'h025a, OK));
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                axi_write(rows[i].addr, rows[i].data, rows[i].strb, rs);
            end else begin
                axi_read(rows[i].addr, rd, rs);
                check(rd, rows[i].exp, "row data");
            end
            check({30'h0, rs}, {30'h0, rows[i].resp}, "row resp");
        end
        check({np_tx, advert}, 32'h025a0000, "side words");
        $display("test register map done");
        for (int c = 0; c < 4; c++) begin
            phy_u.base_page(c[0], c[1], c[1:0]);
            axi_read(8'h14, rd, rs);
            check(rd, {16'h0, c[0], 2'h2, c[1], c[1:0], 10'h001}, "partner");
        end
        axi_read(8'h18, rd, rs);
        check(rd, 32'h0006, "page flag set");
        axi_read(8'h18, rd, rs);
        check(rd, 32'h0004, "page flag cleared");
        // Page arrives in the cycle its flag is read and cleared
        fork
            phy_u.base_page(1'h1, 1'h1, 2'h2);
            begin
                @(posedge ref_clk);
                axi_read(8'h18, rd, rs);
            end
        join
        check(rd, 32'h0004, "read beside page");
        axi_read(8'h18, rd, rs);
        check(rd, 32'h0006, "set beats clear");
        $display("test partner base done");
        for (int k = 0; k < 2; k++) begin
            w = (k == 0) ? 16'ha3c5 : 16'h1e3a;
            phy_u.next_page(w);
            axi_read(8'h20, rd, rs);
            check(rd, {16'h0, w[15], 1'h1, w[13:12], k[0], w[10:0]}, "rx page");
        end
        for (int k = 1; k < 4; k++) begin
            phy_u.sent_page();
            axi_read(8'h1c, rd, rs);
            check(rd, {16'h0, 4'h0, k[0], 11'h25a}, "tx toggle");
        end
        $display("test next pages done");
        for (int k = 1; k >= 0; k--) begin
            phy_u.set_done(k[0]);
            @(posedge ref_clk);
            axi_read(8'h04, rd, rs);
            check(rd, {26'h0, k[0], 5'h0}, "complete");
        end
        do_reset();
        axi_read(8'h1c, rd, rs);
        check(rd, 32'h2000, "tx after reset");
        axi_read(8'h20, rd, rs);
        check(rd, 32'h0, "rx after reset");
        axi_read(8'h14, rd, rs);
        check(rd, 32'h8001, "partner after reset");
        check({np_tx, advert}, 32'h20000000, "side after reset");
        $display("test second reset done");
        stop_test();
    end
endmodule : sanm_regs_bench
`default_nettype wire
